// ### hdl/pwmoc_top.v
// Purpose: Pulse width modulation generator with enable and sync functions.
// Assumes: One clock; pins ENABLE_PIN and SYNC_PIN are asynchronous.
// Notes:   New settings are applied at a period boundary, or at once while the output is off, to avoid runt pulses.
`timescale 1ns/1ns
`default_nettype none
`include "pwmoc_regs.vh"

module pwmoc_top #(
    parameter CLK_HZ = `PWMOC_CLK_HZ
) (
    input  wire        SYS_CLK,
    input  wire        SYS_RST,
    input  wire [7:0]  REG_ADDR,
    input  wire [31:0] REG_WDATA,
    input  wire        REG_WR,
    input  wire        REG_RD,
    output reg  [31:0] REG_RDATA,
    input  wire        ENABLE_PIN,
    input  wire        SYNC_PIN,
    output reg         PULSE_OUT_PIN,
    output wire        AT_TARGET_RATE,
    output wire        BUSY,
    output wire        ERROR_FLAG,
    output wire [7:0]  ERROR_CODE
);
    // Ticks per period equals this value divided by the frequency in tenths.
    // The product stays below 2^32 for any clock this block is meant to run on.
    localparam [31:0] TICK_BASE     = CLK_HZ * `PWMOC_TENTHS;
    localparam [39:0] TICK_DIVIDEND = {8'h00, TICK_BASE};

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_PER  = 2'h1;
    localparam [1:0] ST_HIGH = 2'h2;
    localparam [1:0] ST_WAIT = 2'h3;

    reg  [7:0]  ctrl_q;
    reg  [31:0] freq_q;
    reg  [7:0]  duty_q;
    reg         recalc_q;
    reg  [1:0]  state_q;
    reg  [31:0] per_new_q;
    reg  [31:0] high_new_q;
    reg  [31:0] per_q;
    reg  [31:0] high_q;
    reg         valid_q;
    reg  [31:0] cnt_q;
    reg         force_sync_prev_q;
    reg  [1:0]  filt_prev_q;
    reg  [7:0]  err_code_q;
    reg         err_q;

    wire [1:0]  pin_raw;
    wire [1:0]  filt;
    wire        en_pin_level;
    wire        sync_pin_level;
    wire        sync_rise;
    wire        sync_fall;
    wire        sync_qual;
    wire        force_sync_rise;
    wire        restart;
    wire        enable_act;
    wire        wrap;
    wire        freq_bad;
    wire        duty_bad;
    wire        cmd_ok;
    wire        at_target;
    wire        busy;
    wire        div_done;
    wire [31:0] div_quo;
    reg         div_start;
    reg  [39:0] div_num;
    reg  [31:0] div_den;
    wire [39:0] high_product;

    assign pin_raw = {SYNC_PIN, ENABLE_PIN};

    // Three-stage pin synchronisers; a level counts once stages two and three agree.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_pin
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg filt_q;
            always @(posedge SYS_CLK) begin
                if (SYS_RST) begin
                    s1_q   <= 1'b0;
                    s2_q   <= 1'b0;
                    s3_q   <= 1'b0;
                    filt_q <= 1'b0;
                end else begin
                    s1_q <= pin_raw[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        filt_q <= s3_q;
                    end
                end
            end
            assign filt[gi] = filt_q;
        end
    endgenerate

    assign en_pin_level   = filt[0];
    assign sync_pin_level = filt[1];
    assign sync_rise      = sync_pin_level & ~filt_prev_q[1];
    assign sync_fall      = ~sync_pin_level & filt_prev_q[1];

    assign sync_qual = (ctrl_q[`PWMOC_CTRL_EDGE_HI:`PWMOC_CTRL_EDGE_LO] == `PWMOC_EDGE_RISE)
                       ? sync_rise :
                       (ctrl_q[`PWMOC_CTRL_EDGE_HI:`PWMOC_CTRL_EDGE_LO] == `PWMOC_EDGE_FALL)
                       ? sync_fall :
                       (ctrl_q[`PWMOC_CTRL_EDGE_HI:`PWMOC_CTRL_EDGE_LO] == `PWMOC_EDGE_BOTH)
                       ? (sync_rise | sync_fall) : 1'b0;

    assign force_sync_rise = ctrl_q[`PWMOC_CTRL_FORCE_SYN] & ~force_sync_prev_q;

    assign restart = force_sync_rise |
                     (ctrl_q[`PWMOC_CTRL_EXT_SYNC] & ctrl_q[`PWMOC_CTRL_SYN_CFG] & sync_qual);

    assign enable_act = ctrl_q[`PWMOC_CTRL_FORCE_EN] |
                        (ctrl_q[`PWMOC_CTRL_EXT_EN] & ctrl_q[`PWMOC_CTRL_EN_CFG] & en_pin_level);

    assign freq_bad = (freq_q < `PWMOC_FREQ_MIN) || (freq_q > `PWMOC_FREQ_MAX);
    assign duty_bad = (duty_q > `PWMOC_DUTY_MAX);
    assign cmd_ok   = ~freq_bad & ~duty_bad;

    assign wrap = (cnt_q >= per_q - 32'h00000001);

    assign at_target = enable_act & valid_q & ~err_q & ~recalc_q & (state_q == ST_IDLE);

    assign busy = enable_act & ~at_target & ~err_q;

    assign AT_TARGET_RATE = at_target;
    assign BUSY           = busy;
    assign ERROR_FLAG     = err_q;
    assign ERROR_CODE     = err_code_q;

    assign high_product = {8'h00, div_quo} * {32'h00000000, duty_q};

    // Divider feed: period from the tick dividend, then high time from period times duty.
    always @* begin
        div_start = 1'b0;
        div_num   = TICK_DIVIDEND;
        div_den   = freq_q;
        if (state_q == ST_IDLE && recalc_q && cmd_ok) begin
            div_start = 1'b1;
        end else if (state_q == ST_PER && div_done) begin
            div_start = 1'b1;
            div_num   = high_product;
            div_den   = `PWMOC_PERCENT;
        end
    end

    pwmoc_div #(
        .NW (40),
        .DW (32),
        .CW (6)
    ) u_div (
        .clk      (SYS_CLK),
        .rst      (SYS_RST),
        .start    (div_start),
        .dividend (div_num),
        .divisor  (div_den),
        .done     (div_done),
        .quotient (div_quo)
    );

    // Register writes; a write to frequency or duty asks for a new setting.
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            ctrl_q <= `PWMOC_CTRL_RESET;
            freq_q <= `PWMOC_FREQ_RESET;
            duty_q <= `PWMOC_DUTY_RESET;
        end else if (REG_WR) begin
            case (REG_ADDR)
                `PWMOC_ADDR_CTRL: begin
                    ctrl_q <= REG_WDATA[7:0];
                end
                `PWMOC_ADDR_FREQ: begin
                    freq_q <= REG_WDATA;
                end
                `PWMOC_ADDR_DUTY: begin
                    duty_q <= REG_WDATA[7:0];
                end
                default: begin
                    ctrl_q <= ctrl_q;
                end
            endcase
        end
    end

    // Register reads; unmapped addresses return zero.
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= 32'h00000000;
        end else if (REG_RD) begin
            case (REG_ADDR)
                `PWMOC_ADDR_CTRL: begin
                    REG_RDATA <= {24'h000000, ctrl_q};
                end
                `PWMOC_ADDR_FREQ: begin
                    REG_RDATA <= freq_q;
                end
                `PWMOC_ADDR_DUTY: begin
                    REG_RDATA <= {24'h000000, duty_q};
                end
                `PWMOC_ADDR_STATUS: begin
                    REG_RDATA <= {16'h0000, err_code_q, 3'h0, PULSE_OUT_PIN,
                                  enable_act, err_q, busy, at_target};
                end
                default: begin
                    REG_RDATA <= 32'h00000000;
                end
            endcase
        end else begin
            REG_RDATA <= 32'h00000000;
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            err_q      <= 1'b0;
            err_code_q <= `PWMOC_ERR_NONE;
        end else begin
            err_q <= ~cmd_ok;
            if (freq_bad) begin
                err_code_q <= `PWMOC_ERR_FREQ;
            end else if (duty_bad) begin
                err_code_q <= `PWMOC_ERR_DUTY;
            end else begin
                err_code_q <= `PWMOC_ERR_NONE;
            end
        end
    end

    // Settings sequencer. A write during a calculation is kept and redone afterwards.
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            recalc_q   <= 1'b1;
            state_q    <= ST_IDLE;
            per_new_q  <= 32'h00000000;
            high_new_q <= 32'h00000000;
            per_q      <= 32'h00000001;
            high_q     <= 32'h00000000;
            valid_q    <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (recalc_q) begin
                        // Invalid commands leave the running setting untouched.
                        recalc_q <= 1'b0;
                        if (cmd_ok) begin
                            state_q <= ST_PER;
                        end
                    end
                end
                ST_PER: begin
                    if (div_done) begin
                        per_new_q <= div_quo;
                        state_q   <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    if (div_done) begin
                        high_new_q <= div_quo;
                        state_q    <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // A result worked out while a command went out of range is dropped,
                    // so the running setting stays in force until a valid command.
                    // Switching at the period end or on a restart, or at once while the output is off, avoids a truncated pulse.
                    if (!cmd_ok) begin
                        state_q <= ST_IDLE;
                    end else if (!enable_act || !valid_q || wrap || restart) begin
                        per_q   <= per_new_q;
                        high_q  <= high_new_q;
                        valid_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
            if (REG_WR && (REG_ADDR == `PWMOC_ADDR_FREQ || REG_ADDR == `PWMOC_ADDR_DUTY)) begin
                recalc_q <= 1'b1;
            end
        end
    end

    // Period counter and output stage.
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            cnt_q             <= 32'h00000000;
            PULSE_OUT_PIN     <= 1'b0;
            force_sync_prev_q <= 1'b0;
            filt_prev_q       <= 2'h0;
        end else begin
            force_sync_prev_q <= ctrl_q[`PWMOC_CTRL_FORCE_SYN];
            filt_prev_q       <= filt;
            if (!enable_act || !valid_q) begin
                cnt_q <= 32'h00000000;
            end else if (restart || wrap) begin
                cnt_q <= 32'h00000000;
            end else begin
                cnt_q <= cnt_q + 32'h00000001;
            end
            PULSE_OUT_PIN <= enable_act & valid_q & (cnt_q < high_q);
        end
    end
endmodule // pwmoc_top

`default_nettype wire

// ### hdl/pwmoc_regs.vh
// Purpose: Constants for the pulse width modulation output block.
// Assumes: 20 MHz system clock, word-aligned byte addresses.
// Notes:   Included by the block only; the bench files use literal values.
//
// Functional notes
// - External enable pin may activate output when allowed and configured.
// - Software force enable activates the generator regardless of the pin.
// - External sync pin may restart the period timer when allowed and configured.
// - Rising edge of force sync restarts the period timer.
// - Frequency is tenths of hertz, valid from 1 to 200000.
// - Duty is an 8-bit percentage, 0 to 100, the high fraction.
// - At target rate only while output runs at commanded frequency and duty.
// - Busy when enabled but output not yet at commanded frequency.
// - Busy clears on at target rate, error, or enable withdrawn.
// - Busy stays low when a command change takes effect immediately.
// - On error set error flag and show error type on error code.
// - Output held low unless force enable or allowed external enable.
// - Qualifying sync edge abandons current period and starts a new one.
// - Sync edge selectable rising, falling or both; rising by default.
`ifndef PWMOC_REGS_VH
`define PWMOC_REGS_VH

`define PWMOC_ADDR_CTRL      8'h00
`define PWMOC_ADDR_FREQ      8'h04
`define PWMOC_ADDR_DUTY      8'h08
`define PWMOC_ADDR_STATUS    8'h0c

`define PWMOC_CTRL_EXT_EN    0
`define PWMOC_CTRL_FORCE_EN  1
`define PWMOC_CTRL_EXT_SYNC  2
`define PWMOC_CTRL_FORCE_SYN 3
`define PWMOC_CTRL_EN_CFG    4
`define PWMOC_CTRL_SYN_CFG   5
`define PWMOC_CTRL_EDGE_LO   6
`define PWMOC_CTRL_EDGE_HI   7

`define PWMOC_EDGE_RISE      2'h0
`define PWMOC_EDGE_FALL      2'h1
`define PWMOC_EDGE_BOTH      2'h2

`define PWMOC_STAT_TARGET    0
`define PWMOC_STAT_BUSY      1
`define PWMOC_STAT_ERROR     2
`define PWMOC_STAT_ACTIVE    3
`define PWMOC_STAT_OUT       4
`define PWMOC_STAT_CODE_LO   8
`define PWMOC_STAT_CODE_HI   15

`define PWMOC_CTRL_RESET     8'h00
`define PWMOC_FREQ_RESET     32'h00000001
`define PWMOC_DUTY_RESET     8'h00

`define PWMOC_FREQ_MIN       32'h00000001
`define PWMOC_FREQ_MAX       32'h00030d40
`define PWMOC_DUTY_MAX       8'h64
`define PWMOC_PERCENT        32'h00000064

`define PWMOC_ERR_NONE       8'h00
`define PWMOC_ERR_FREQ       8'h01
`define PWMOC_ERR_DUTY       8'h02

`define PWMOC_CLK_HZ         20000000
`define PWMOC_TENTHS         10

`endif

// ### hdl/pwmoc_div.v
// Purpose: Restoring unsigned divider, one quotient bit per clock.
// Assumes: Divisor is never zero while a division runs.
// Notes:   Quotient comes from a register; done is a one-cycle pulse.
`timescale 1ns/1ns
`default_nettype none

module pwmoc_div #(
    parameter NW = 40,
    parameter DW = 32,
    parameter CW = 6
) (
    input  wire          clk,
    input  wire          rst,
    input  wire          start,
    input  wire [NW-1:0] dividend,
    input  wire [DW-1:0] divisor,
    output reg           done,
    output wire [DW-1:0] quotient
);
    reg  [DW:0]   rem_q;
    reg  [NW-1:0] quo_q;
    reg  [DW-1:0] dsr_q;
    reg  [CW-1:0] cnt_q;
    reg           run_q;
    wire [DW:0]   shifted;
    wire [DW:0]   trial;

    assign shifted  = {rem_q[DW-1:0], quo_q[NW-1]};
    assign trial    = shifted - {1'b0, dsr_q};
    assign quotient = quo_q[DW-1:0];

    always @(posedge clk) begin
        if (rst) begin
            rem_q <= {(DW+1){1'b0}};
            quo_q <= {NW{1'b0}};
            dsr_q <= {DW{1'b0}};
            cnt_q <= {CW{1'b0}};
            run_q <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                rem_q <= {(DW+1){1'b0}};
                quo_q <= dividend;
                dsr_q <= divisor;
                cnt_q <= NW[CW-1:0];
                run_q <= 1'b1;
            end else if (run_q) begin
                if (!trial[DW]) begin
                    rem_q <= trial;
                end else begin
                    rem_q <= shifted;
                end
                quo_q <= {quo_q[NW-2:0], ~trial[DW]};
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q == {{(CW-1){1'b0}}, 1'b1}) begin
                    run_q <= 1'b0;
                    done  <= 1'b1;
                end
            end
        end
    end
endmodule // pwmoc_div

`default_nettype wire

// ### testbench/pwmoc_field.sv
// Purpose: Field side model that drives the external enable and sync pins.
// Assumes: The bench asks for pin levels; the pins follow after a lag.
// Notes:   The pins have no pull, so they are always driven to a level.
`timescale 1ns/1ns
`default_nettype none
module pwmoc_field (
    input  wire logic       clk,
    input  wire logic [1:0] lag,
    input  wire logic       en_req,
    input  wire logic       syn_req,
    output var  logic       en_pin,
    output var  logic       syn_pin
);
    logic [3:0] en_q  = 4'h0;
    logic [3:0] syn_q = 4'h0;
    initial en_pin = 1'b0;
    initial syn_pin = 1'b0;
    // A longer lag stands for a slow field wire, so edges reach the block late.
    always @(posedge clk) begin
        en_q    <= {en_q[2:0], en_req};
        syn_q   <= {syn_q[2:0], syn_req};
        en_pin  <= en_q[lag];
        syn_pin <= syn_q[lag];
    end
endmodule // pwmoc_field
`default_nettype wire

// ### testbench/pwmoc_monitor.sv
// Purpose: Port checker for the pulse width modulation block.
// Assumes: One clock domain, synchronous active high reset.
// Notes:   Attached to the top module by the bind at the foot.
`timescale 1ns/1ns
`default_nettype none
module pwmoc_monitor #(
    parameter CLK_HZ = 20000000
) (
    input wire logic        SYS_CLK,
    input wire logic        SYS_RST,
    input wire logic [7:0]  REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic        ENABLE_PIN,
    input wire logic        SYNC_PIN,
    input wire logic        PULSE_OUT_PIN,
    input wire logic        AT_TARGET_RATE,
    input wire logic        BUSY,
    input wire logic        ERROR_FLAG,
    input wire logic [7:0]  ERROR_CODE
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (SYS_RST);
    sequence s_stat_rd;
        REG_RD && REG_ADDR == 8'h0c;
    endsequence
    sequence s_ctrl_off;
        REG_WR && REG_ADDR == 8'h00 && REG_WDATA[1:0] == 2'h0;
    endsequence
    sequence s_set_wr;
        REG_WR && (REG_ADDR == 8'h04 || REG_ADDR == 8'h08);
    endsequence
    sequence s_freq_bad;
        REG_WR && REG_ADDR == 8'h04 && (REG_WDATA == 32'h0 || REG_WDATA > 32'h00030d40);
    endsequence
    AST_STATUS_READ: assert property (s_stat_rd |=> REG_RDATA[15:8] == $past(ERROR_CODE)
        && REG_RDATA[2:0] == {$past(ERROR_FLAG), $past(BUSY), $past(AT_TARGET_RATE)})
        else $error("status read does not match the flags");
    AST_RDATA_IDLE: assert property (!REG_RD |=> REG_RDATA == 32'h0)
        else $error("read data not zero outside a read");
    // The flag is registered from the stored command, so it shows two edges after the write.
    AST_FREQ_ERR: assert property (s_freq_bad |-> ##2 ERROR_FLAG && ERROR_CODE == 8'h01)
        else $error("bad frequency not flagged");
    AST_DUTY_ERR: assert property (REG_WR && REG_ADDR == 8'h08 && REG_WDATA[7:0] > 8'h64
        |-> ##2 ERROR_FLAG) else $error("bad duty not flagged");
    AST_CODE_FLAG: assert property (ERROR_FLAG == (ERROR_CODE != 8'h00))
        else $error("error code and flag disagree");
    AST_BUSY_DEF: assert property (BUSY |-> !AT_TARGET_RATE && !ERROR_FLAG)
        else $error("busy together with target or error");
    AST_TARGET_OK: assert property (AT_TARGET_RATE |-> !ERROR_FLAG)
        else $error("target rate reported during an error");
    AST_SET_DROP: assert property (s_set_wr |=> !AT_TARGET_RATE)
        else $error("target rate kept after a new setting");
    AST_OFF_LOW: assert property (s_ctrl_off ##1 !REG_WR |-> ##1 !PULSE_OUT_PIN)
        else $error("output high after disable");
    AST_BUSY_OFF: assert property (s_ctrl_off ##1 !REG_WR |-> ##1 !BUSY)
        else $error("busy kept after disable");
endmodule // pwmoc_monitor
bind pwmoc_top pwmoc_monitor #(.CLK_HZ(CLK_HZ)) i_monitor (
    .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .ENABLE_PIN(ENABLE_PIN),
    .SYNC_PIN(SYNC_PIN), .PULSE_OUT_PIN(PULSE_OUT_PIN), .AT_TARGET_RATE(AT_TARGET_RATE),
    .BUSY(BUSY), .ERROR_FLAG(ERROR_FLAG), .ERROR_CODE(ERROR_CODE)
);
`default_nettype wire

// ### testbench/test_pwmoc_top.sv
// Purpose: Self-checking bench for the pulse width modulation block.
// Assumes: 20 MHz clock; 20 kHz and duty 50 give 500 high and 500 low cycles.
// Notes:   Settings switch at period ends, or at once while the output is off, so every wait is a bounded loop.
`timescale 1ns/1ns
`default_nettype none
module test_pwmoc_top;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic        en_req  = 1'b0;
    logic        syn_req = 1'b0;
    logic [1:0]  lag     = 2'h0;
    wire  [31:0] rdata;
    wire  [7:0]  code;
    wire         en_pin, syn_pin, pout, at_rate, busy, err;
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          n, hi, nb;
    logic [31:0] d;
    always #25 sys_clk = ~sys_clk;
    pwmoc_top i_dut (
        .SYS_CLK(sys_clk), .SYS_RST(sys_rst), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .ENABLE_PIN(en_pin),
        .SYNC_PIN(syn_pin), .PULSE_OUT_PIN(pout), .AT_TARGET_RATE(at_rate),
        .BUSY(busy), .ERROR_FLAG(err), .ERROR_CODE(code)
    );
    pwmoc_field i_field (.clk(sys_clk), .lag(lag), .en_req(en_req), .syn_req(syn_req),
        .en_pin(en_pin), .syn_pin(syn_pin));
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic pins(input logic e, input logic s);
        @(posedge sys_clk);
        en_req  <= e;
        syn_req <= s;
    endtask
    // Counts high output cycles and busy cycles over a fixed window.
    task automatic win(input int lim);
        hi = 0;
        nb = 0;
        repeat (lim) begin
            @(posedge sys_clk);
            #1;
            hi += (pout === 1'b1);
            nb += (busy !== 1'b0);
        end
    endtask
    task automatic wait_on(input logic at, input logic lvl, input int lim);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while ((at ? at_rate : pout) !== lvl && n < lim);
        if ((at ? at_rate : pout) !== lvl) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    task automatic t_regs;
        logic [7:0]  a [5] = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h08};
        logic [31:0] v [5] = '{32'h0, 32'h00030d41, 32'h00030d40, 32'h65, 32'h32};
        logic [7:0]  c [5] = '{8'h01, 8'h01, 8'h00, 8'h02, 8'h00};
        for (int i = 0; i < 5; i++) begin
            wr_reg(a[i], v[i]);
            rd_reg(8'h0c);
            chk({d[15:8], 7'h0, d[2]}, {c[i], 7'h0, c[i] != 8'h00});
            chk(code, c[i]);
        end
        rd_reg(8'h10);
        chk(d, 32'h0);
        $display("register test done");
    endtask
    task automatic t_rate;
        win(200);
        wr_reg(8'h00, 32'h02);
        win(4);
        chk(at_rate, 1'b1);
        chk(busy, 1'b0);
        wait_on(1'b0, 1'b0, 1100);
        wait_on(1'b0, 1'b1, 1100);
        chk(n, 500);
        wait_on(1'b0, 1'b0, 1100);
        chk(n, 500);
        wait_on(1'b0, 1'b0, 1100);
        win(100);
        wr_reg(8'h00, 32'h0a);
        win(20);
        chk(hi > 0, 1'b1);
        wr_reg(8'h00, 32'h02);
        $display("rate and forced sync test done");
    endtask
    task automatic t_sync_ext;
        logic [7:0] cc [5] = '{8'h26, 8'h66, 8'h66, 8'ha6, 8'h22};
        logic       pl [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
        logic       ex [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
        for (int i = 0; i < 5; i++) begin
            wr_reg(8'h00, {24'h0, cc[i]});
            wait_on(1'b0, 1'b1, 1100);
            wait_on(1'b0, 1'b0, 1100);
            win(100);
            pins(1'b0, pl[i]);
            win(30);
            chk(hi > 0, ex[i]);
        end
        $display("external sync test done");
    endtask
    task automatic t_ext_en;
        lag <= 2'h3;
        pins(1'b1, 1'b0);
        wr_reg(8'h00, 32'h01);
        win(1100);
        chk(hi, 0);
        wr_reg(8'h00, 32'h11);
        win(1100);
        chk(hi > 0, 1'b1);
        pins(1'b0, 1'b0);
        win(10);
        win(1100);
        chk(hi, 0);
        $display("external enable test done");
    endtask
    task automatic t_busy;
        wr_reg(8'h00, 32'h02);
        win(1100);
        wr_reg(8'h04, 32'h000186a0);
        win(3);
        chk(busy, 1'b1);
        wait_on(1'b1, 1'b1, 2500);
        chk(busy, 1'b0);
        wr_reg(8'h04, 32'h00030d40);
        wr_reg(8'h08, 32'h65);
        win(3);
        chk(busy, 1'b0);
        wr_reg(8'h08, 32'h32);
        win(3);
        chk(busy, 1'b1);
        wr_reg(8'h00, 32'h00);
        win(3);
        chk(busy, 1'b0);
        $display("busy test done");
    endtask
    task automatic t_flat;
        logic [7:0] dv [2] = '{8'h64, 8'h00};
        for (int i = 0; i < 2; i++) begin
            wr_reg(8'h00, 32'h00);
            wr_reg(8'h08, {24'h0, dv[i]});
            win(150);
            wr_reg(8'h00, 32'h02);
            win(3);
            win(2100);
            chk(hi, (dv[i] != 8'h00) ? 2100 : 0);
            chk(nb, 0);
        end
        $display("flat duty test done");
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_regs();
        t_rate();
        t_sync_ext();
        t_ext_en();
        t_busy();
        t_flat();
        print_verdict();
    end
endmodule // test_pwmoc_top
`default_nettype wire
